// ---- logic/rsmx_defines.svh ----
// Constants for the reset-indicator and interrupt pin multiplexer.
// Assumes inclusion by the package and the pin mux module only.
`ifndef RSMX_DEFINES_SVH
`define RSMX_DEFINES_SVH
// -----------------------------------------------------------------
// Register map (byte addresses, word aligned)
// -----------------------------------------------------------------
`define RSMX_CTRL_ADDR 8'h00
`define RSMX_STAT_ADDR 8'h04
`define RSMX_SEL_NONE 2'h0
`define RSMX_SEL_CTRL 2'h1
`define RSMX_SEL_STAT 2'h2
// -----------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------
`define RSMX_CTRL_W 13
`define RSMX_CTRL_RST 13'h0000
`define RSMX_B_FORCE 0
`define RSMX_B_SHOW 1
`define RSMX_B_SIZE_REFLECT_ENABLE 2
`define RSMX_B_STATUS_REFLECT_ENABLE 3
`define RSMX_B_BUSRD 4
`define RSMX_B_PU_LO 5
`define RSMX_B_PU_HI 6
`define RSMX_B_SPIRD 7
`define RSMX_B_SCIRD 8
`define RSMX_B_TMRRD 9
`define RSMX_B_SCI_OD 10
`define RSMX_B_SPI_OD 11
`define RSMX_B_SPI_PU 12
// -----------------------------------------------------------------
// Pin groups
// -----------------------------------------------------------------
`define RSMX_SZ_HI 7
`define RSMX_SZ_LO 6
`define RSMX_PS_HI 5
`define RSMX_PS_LO 2
// -----------------------------------------------------------------
// Synchroniser reset levels
// -----------------------------------------------------------------
`define RSMX_RSTPIN_IDLE 2'h3
`endif

// ---- logic/rsmx_pin_mux.sv ----
// Reset-indicator output and external interrupt pin multiplexer,
// with pullup, open-drain, drive-reduce and scan-only pad control.
// Assumes one 20 MHz clock, synchronous reset, AHB-Lite single word
// transfers and pad cells that resolve o/oe/pu themselves.
//
// How it works
// - Internal reset always asserts reset indicator.
// - Force bit asserts indicator while set.
// - Show-interrupt bit mirrors interrupt request.
// - Otherwise indicator stays negated.
// - Size enable puts transfer size on 7:6.
// - Status enable puts processor status on 5:2.
// - Reflected pins lose edge-port input in emulation.
// - Serial pullup enables reset to zero.
// - Pullup disconnected whenever pin drives.
// - Sync digital inputs; reset unsynced in stop.
// - Test data out is tristate, no input.
// - Scan-only input and reset-output paths.
// - Software selects serial open-drain and pullup.
// - Debug inputs unsynced; event pin open-drain.
// - Per-group drive-reduce control bits.
// - Indicator tristated in PLL test mode.
// - Mirrored pins show size and status.
`timescale 1ns/10ps
module rsmx_pin_mux
	import rsmx_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Core side
	input wire logic irq_pending,
	input wire logic emul_mode,
	input wire logic stop_mode,
	input wire logic [1:0] core_transfer_size,
	input wire logic [3:0] core_processor_status,
	// Reset pins
	output logic reset_indicator_out_n,
	output logic reset_indicator_oe,
	input wire logic pll_test_pin,
	input wire logic reset_pin_n_i,
	output logic reset_pin_o,
	output logic reset_pin_oe,
	output logic reset_req_n,
	// Interrupt pins and edge port
	input wire logic [7:0] int_pin_i,
	output rsmx_int_pad_t int_pad,
	input wire logic [7:0] eport_out,
	input wire logic [7:0] eport_oe,
	output logic [7:0] eport_in,
	// Serial and SPI pads: oe from their owning modules
	input wire logic [3:0] sci_oe,
	input wire logic [3:0] spi_oe,
	output logic [3:0] sci_pu,
	output logic [3:0] spi_pu,
	output logic sci_open_drain,
	output logic spi_open_drain,
	// Drive reduction: bus, spi, serial, timer
	output logic [3:0] drive_reduce,
	// Boundary scan and debug
	input wire logic bscan_en,
	input wire logic [2:0] scan_pin_i,
	output logic [2:0] scan_capture,
	input wire logic scan_reset_drive,
	input wire logic tdo_data,
	input wire logic tdo_drive,
	output logic tdo_o,
	output logic tdo_oe,
	input wire logic [2:0] jtag_pin_i,
	output logic [2:0] jtag_in,
	output logic [3:0] debug_pu,
	input wire logic debug_event_pin_i,
	input wire logic debug_event_drive,
	output logic debug_event_pin_o,
	output logic debug_event_pin_oe,
	output logic debug_event_pin_pu,
	output logic debug_event_in
);
	// -----------------------------------------------------------------
	// Address decode
	// -----------------------------------------------------------------
	// Word decode, shared by the write and read paths
	function automatic logic [1:0] rsmx_dec(input logic [31:0] a);
		logic [1:0] s;
		s = `RSMX_SEL_NONE;
		if (a[7:0] == `RSMX_CTRL_ADDR) begin
			s = `RSMX_SEL_CTRL;
		end else if (a[7:0] == `RSMX_STAT_ADDR) begin
			s = `RSMX_SEL_STAT;
		end
		return s;
	endfunction

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	rsmx_state_t q;
	rsmx_state_t d;
	logic addr_ok;
	logic [`RSMX_CTRL_W-1:0] c;

	assign addr_ok = hsel & htrans[1] & hready;
	assign c = q.ctrl_q;

	// Next state: bus writes, read capture, synchronisers
	always_comb begin
		d = q;
		d.wr_pend_q = addr_ok & hwrite;
		d.wsel_q = rsmx_dec(haddr);
		// Status register writes are dropped, only control is writable
		if (q.wr_pend_q && q.wsel_q == `RSMX_SEL_CTRL) begin
			d.ctrl_q = hwdata[`RSMX_CTRL_W-1:0];
		end
		// Read data from d so a write just before is seen
		if (addr_ok && !hwrite) begin
			case (rsmx_dec(haddr))
				`RSMX_SEL_CTRL: begin
					d.rdata_q = {{(32-`RSMX_CTRL_W){1'b0}}, d.ctrl_q};
				end
				`RSMX_SEL_STAT: begin
					d.rdata_q = {20'h00000, q.int_s2_q, q.pll_s_q[1],
						q.rstpin_s_q[1], irq_pending, reset_indicator_out_n};
				end
				default: begin
					d.rdata_q = 32'h00000000;
				end
			endcase
		end
		// Two-flop synchronisers for pin inputs
		d.rstpin_s_q = {q.rstpin_s_q[0], reset_pin_n_i};
		d.pll_s_q = {q.pll_s_q[0], pll_test_pin};
		d.int_s1_q = int_pin_i;
		d.int_s2_q = q.int_s1_q;
	end

	// Register the whole state; every mux bit clears on reset except the reset pin sync, which loads high
	always_ff @(posedge core_clk) begin
		if (rst) begin
			q <= '0;
			q.ctrl_q <= `RSMX_CTRL_RST;
			// Reset pin sync starts high, so release brings no false request
			q.rstpin_s_q <= `RSMX_RSTPIN_IDLE;
		end else begin
			q <= d;
		end
	end

	// -----------------------------------------------------------------
	// Bus answer: zero wait, always OKAY
	// -----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.rdata_q;

	// -----------------------------------------------------------------
	// Reset indicator
	// -----------------------------------------------------------------
	// Reset taken straight from rst so the pin drops in the same cycle
	always_comb begin
		if (rst) begin
			reset_indicator_out_n = 1'b0;
		end else if (c[`RSMX_B_FORCE]) begin
			reset_indicator_out_n = 1'b0;
		end else if (c[`RSMX_B_SHOW]) begin
			reset_indicator_out_n = ~irq_pending;
		end else begin
			reset_indicator_out_n = 1'b1;
		end
	end
	assign reset_indicator_oe = ~q.pll_s_q[1];

	// Reset input: raw in stop mode since the clock may be halted
	assign reset_req_n = stop_mode ? reset_pin_n_i : q.rstpin_s_q[1];
	assign reset_pin_o = 1'b0;
	assign reset_pin_oe = bscan_en & scan_reset_drive;
	assign scan_capture = bscan_en ? scan_pin_i : 3'h0;

	// -----------------------------------------------------------------
	// Interrupt pins
	// -----------------------------------------------------------------
	// Per-pin select between edge port and core mirror
	always_comb begin
		logic [7:0] mir;
		mir = 8'h00;
		int_pad.o = eport_out;
		int_pad.oe = eport_oe;
		if (c[`RSMX_B_SIZE_REFLECT_ENABLE]) begin
			mir[`RSMX_SZ_HI:`RSMX_SZ_LO] = 2'h3;
			int_pad.o[`RSMX_SZ_HI:`RSMX_SZ_LO] = core_transfer_size;
		end
		if (c[`RSMX_B_STATUS_REFLECT_ENABLE]) begin
			mir[`RSMX_PS_HI:`RSMX_PS_LO] = 4'hf;
			int_pad.o[`RSMX_PS_HI:`RSMX_PS_LO] = core_processor_status;
		end
		int_pad.oe = int_pad.oe | mir;
		// Pullups only on pins not being driven
		int_pad.pu = ~int_pad.oe;
		// Mirrored pins feed nothing back to the edge port in emulation
		eport_in = q.int_s2_q & ~(mir & {8{emul_mode}});
	end

	// -----------------------------------------------------------------
	// Serial, SPI, drive reduction
	// -----------------------------------------------------------------
	assign sci_pu[1:0] = {2{c[`RSMX_B_PU_LO]}} & ~sci_oe[1:0];
	assign sci_pu[3:2] = {2{c[`RSMX_B_PU_HI]}} & ~sci_oe[3:2];
	assign spi_pu = {4{c[`RSMX_B_SPI_PU]}} & ~spi_oe;
	assign sci_open_drain = c[`RSMX_B_SCI_OD];
	assign spi_open_drain = c[`RSMX_B_SPI_OD];
	assign drive_reduce = {c[`RSMX_B_TMRRD], c[`RSMX_B_SCIRD],
		c[`RSMX_B_SPIRD], c[`RSMX_B_BUSRD]};

	// -----------------------------------------------------------------
	// Debug and test port
	// -----------------------------------------------------------------
	// Test clock domain samples these itself, so no sync here
	assign jtag_in = jtag_pin_i;
	assign debug_pu = 4'hf;
	assign tdo_o = tdo_data;
	assign tdo_oe = tdo_drive;
	assign debug_event_pin_o = 1'b0;
	assign debug_event_pin_oe = debug_event_drive;
	assign debug_event_pin_pu = ~debug_event_drive;
	assign debug_event_in = debug_event_pin_i;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	chk_ind_in_reset: assert property (@(posedge core_clk)
		rst |-> !reset_indicator_out_n)
		else $error("indicator not asserted in reset");
	chk_ind_force: assert property (@(posedge core_clk) disable iff (rst)
		(q.wr_pend_q && q.wsel_q == `RSMX_SEL_CTRL && hwdata[`RSMX_B_FORCE])
		|=> !reset_indicator_out_n)
		else $error("force write did not assert indicator");
	chk_ind_show: assert property (@(posedge core_clk) disable iff (rst)
		(!c[`RSMX_B_FORCE] && c[`RSMX_B_SHOW]) |-> reset_indicator_out_n != irq_pending)
		else $error("indicator does not follow interrupt");
	chk_ind_idle: assert property (@(posedge core_clk) disable iff (rst)
		(c[`RSMX_B_FORCE] == 1'b0 && !c[`RSMX_B_SHOW]) |-> reset_indicator_out_n)
		else $error("indicator asserted with no cause");
	chk_size_mirror: assert property (@(posedge core_clk) disable iff (rst)
		c[`RSMX_B_SIZE_REFLECT_ENABLE] |-> (int_pad.o[`RSMX_SZ_HI:`RSMX_SZ_LO] == core_transfer_size
		&& &int_pad.oe[`RSMX_SZ_HI:`RSMX_SZ_LO]))
		else $error("size not mirrored");
	chk_status_mirror: assert property (@(posedge core_clk) disable iff (rst)
		c[`RSMX_B_STATUS_REFLECT_ENABLE] |-> (int_pad.o[`RSMX_PS_HI:`RSMX_PS_LO] == core_processor_status
		&& &int_pad.oe[`RSMX_PS_HI:`RSMX_PS_LO]))
		else $error("status not mirrored");
	chk_emul_lost: assert property (@(posedge core_clk) disable iff (rst)
		(emul_mode && c[`RSMX_B_SIZE_REFLECT_ENABLE]) |-> eport_in[`RSMX_SZ_HI:`RSMX_SZ_LO] == 2'h0)
		else $error("mirrored pin leaked to edge port");
	chk_reset_clear: assert property (@(posedge core_clk)
		$fell(rst) |-> (c == `RSMX_CTRL_RST && sci_pu == 4'h0))
		else $error("control not clear after reset");
	chk_pu_off_drive: assert property (@(posedge core_clk) disable iff (rst)
		(int_pad.pu & int_pad.oe) == 8'h00 && (sci_pu & sci_oe) == 4'h0)
		else $error("pullup on driven pin");
	chk_pll_tristate: assert property (@(posedge core_clk) disable iff (rst)
		pll_test_pin [*3] |-> !reset_indicator_oe)
		else $error("indicator driven in pll test");
	chk_rst_sync: assert property (@(posedge core_clk) disable iff (rst)
		!stop_mode |-> reset_req_n == $past(reset_pin_n_i, 2))
		else $error("reset input not two-flop synced");
	chk_status_lost: assert property (@(posedge core_clk) disable iff (rst)
		(emul_mode && c[`RSMX_B_STATUS_REFLECT_ENABLE]) |-> eport_in[`RSMX_PS_HI:`RSMX_PS_LO] == 4'h0)
		else $error("mirrored status pin leaked to edge port");
	chk_emul_normal: assert property (@(posedge core_clk) disable iff (rst)
		!emul_mode |-> eport_in == q.int_s2_q)
		else $error("edge port lost pin outside emulation");
	chk_mirror_off: assert property (@(posedge core_clk) disable iff (rst)
		(!c[`RSMX_B_SIZE_REFLECT_ENABLE] && !c[`RSMX_B_STATUS_REFLECT_ENABLE]) |->
		(int_pad.o == eport_out && int_pad.oe == eport_oe))
		else $error("interrupt pins not in normal function");
	chk_force_hold: assert property (@(posedge core_clk) disable iff (rst)
		c[`RSMX_B_FORCE] |-> !reset_indicator_out_n)
		else $error("indicator released while force set");
	chk_drive_write: assert property (@(posedge core_clk) disable iff (rst)
		(q.wr_pend_q && q.wsel_q == `RSMX_SEL_CTRL) |=> drive_reduce == $past({
		hwdata[`RSMX_B_TMRRD], hwdata[`RSMX_B_SCIRD],
		hwdata[`RSMX_B_SPIRD], hwdata[`RSMX_B_BUSRD]}))
		else $error("drive reduce bits not taken from write");
	chk_od_write: assert property (@(posedge core_clk) disable iff (rst)
		(q.wr_pend_q && q.wsel_q == `RSMX_SEL_CTRL) |=> {spi_open_drain, sci_open_drain}
		== $past({hwdata[`RSMX_B_SPI_OD], hwdata[`RSMX_B_SCI_OD]}))
		else $error("open-drain bits not taken from write");
	chk_scan_only: assert property (@(posedge core_clk) disable iff (rst)
		!bscan_en |-> (scan_capture == 3'h0 && !reset_pin_oe))
		else $error("scan path active outside scan");
	chk_de_open_drain: assert property (@(posedge core_clk) disable iff (rst)
		debug_event_pin_oe |-> (!debug_event_pin_o && !debug_event_pin_pu))
		else $error("debug event pin not open-drain");
	chk_req_stop: assert property (@(posedge core_clk) disable iff (rst)
		stop_mode |-> reset_req_n == reset_pin_n_i)
		else $error("reset input not raw in stop");
	chk_pll_off: assert property (@(posedge core_clk) disable iff (rst)
		(!pll_test_pin) [*3] |-> reset_indicator_oe)
		else $error("indicator not driven outside pll test");
endmodule // rsmx_pin_mux

// ---- logic/rsmx_pkg.sv ----
// Types for the reset-indicator and interrupt pin multiplexer.
// Assumes the defines header sits beside it on the include path.
`include "rsmx_defines.svh"
package rsmx_pkg;
	// -----------------------------------------------------------------
	// Pad bundle: data out, output enable, pullup enable
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
		logic [7:0] pu;
	} rsmx_int_pad_t;
	// -----------------------------------------------------------------
	// Whole module state
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [`RSMX_CTRL_W-1:0] ctrl_q;
		logic wr_pend_q;
		logic [1:0] wsel_q;
		logic [31:0] rdata_q;
		logic [1:0] rstpin_s_q;
		logic [1:0] pll_s_q;
		logic [7:0] int_s1_q;
		logic [7:0] int_s2_q;
	} rsmx_state_t;
endpackage

// ---- testbench/rsmx_board.sv ----
// Board-side model: reset button, PLL test strap and interrupt sources.
// Assumes the bench changes its requests right after a clock edge.
`timescale 1ns/10ps
module rsmx_board (
	input wire logic want_reset,
	input wire logic want_pll_test,
	input wire logic [7:0] int_lvl,
	output logic reset_pin_n_i,
	output logic pll_test_pin,
	output logic [7:0] int_pin_i
);
	// Button pulls the line low, board pullup holds it high otherwise
	assign reset_pin_n_i = ~want_reset;
	// No strap data driven here, so a repurposed indicator is harmless
	assign pll_test_pin = want_pll_test;
	assign int_pin_i = int_lvl;
endmodule // rsmx_board

// ---- testbench/testbench.sv ----
// Self-checking bench for the reset-indicator and interrupt pin mux.
// Assumes the board model is compiled first and CTRL sits at 0x00.
`timescale 1ns/10ps
module testbench;
	import rsmx_pkg::*;
	logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, irq_pending = 0, emul_mode = 0;
	logic stop_mode = 0, bscan_en = 0, scan_reset_drive = 0, tdo_data = 0, tdo_drive = 0;
	logic debug_event_pin_i = 0, debug_event_drive = 0, want_reset = 0, want_pll_test = 0;
	logic hready, hreadyout, hresp, reset_indicator_out_n, reset_indicator_oe, reset_req_n;
	logic reset_pin_n_i, pll_test_pin, reset_pin_o, reset_pin_oe, sci_open_drain;
	logic spi_open_drain, tdo_o, tdo_oe, debug_event_pin_o, debug_event_pin_oe;
	logic debug_event_pin_pu, debug_event_in;
	logic [1:0] htrans = 0, core_transfer_size = 0;
	logic [2:0] hsize = 3'h2, scan_pin_i = 0, scan_capture, jtag_pin_i = 0, jtag_in;
	logic [3:0] core_processor_status = 0, sci_oe = 0, spi_oe = 0, sci_pu, spi_pu;
	logic [3:0] drive_reduce, debug_pu;
	logic [7:0] int_lvl = 0, int_pin_i, eport_out = 0, eport_oe = 0, eport_in;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	rsmx_int_pad_t int_pad;
	int miscompares = 0, n_compared = 0;

	// ------------------------------------------------------------
	// Clock, bus wiring and instances
	// ------------------------------------------------------------
	always #25 core_clk = ~core_clk;
	assign hready = hreadyout;
	rsmx_board board (.want_reset, .want_pll_test, .int_lvl, .reset_pin_n_i, .pll_test_pin,
		.int_pin_i);
	rsmx_pin_mux uut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata, .irq_pending, .emul_mode, .stop_mode,
		.core_transfer_size, .core_processor_status, .reset_indicator_out_n,
		.reset_indicator_oe, .pll_test_pin, .reset_pin_n_i, .reset_pin_o, .reset_pin_oe,
		.reset_req_n, .int_pin_i, .int_pad, .eport_out, .eport_oe, .eport_in, .sci_oe,
		.spi_oe, .sci_pu, .spi_pu, .sci_open_drain, .spi_open_drain, .drive_reduce,
		.bscan_en, .scan_pin_i, .scan_capture, .scan_reset_drive, .tdo_data, .tdo_drive,
		.tdo_o, .tdo_oe, .jtag_pin_i, .jtag_in, .debug_pu, .debug_event_pin_i,
		.debug_event_drive, .debug_event_pin_o, .debug_event_pin_oe, .debug_event_pin_pu,
		.debug_event_in);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One single-word transfer; no wait count assumed, watchdog cuts hangs
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hready !== 1'b1);
		rd = hrdata;
		chk("resp", hresp, 0);
	endtask
	task automatic print_verdict;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Watchdog, far beyond the 64 or so cycles the tests need
	initial begin
		repeat (5000) @(posedge core_clk);
		miscompares++;
		print_verdict();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge core_clk);
		#1 chk("ind_rst", reset_indicator_out_n, 0);
		repeat (5) @(posedge core_clk);
		rst <= 0;
		bus(0, 8'h00, 0);
		chk("ctrl_rst", rd, 0);
		chk("pu_rst", {spi_pu, sci_pu}, 0);
		chk("ind_idle", reset_indicator_out_n, 1);
		chk("req_idle", reset_req_n, 1);
		// Force wins over show-interrupt with no request pending
		bus(1, 8'h00, 32'h3);
		#1 chk("force", reset_indicator_out_n, 0);
		bus(1, 8'h00, 32'h2);
		#1 chk("show_lo", reset_indicator_out_n, 1);
		@(posedge core_clk) irq_pending <= 1;
		#1 chk("show_hi", reset_indicator_out_n, 0);
		bus(1, 8'h00, 32'h0);
		#1 chk("clear", reset_indicator_out_n, 1);
		// Mid-run reset with show set and no request still asserts
		bus(1, 8'h00, 32'h2);
		@(posedge core_clk) irq_pending <= 0;
		rst <= 1;
		#1 chk("ind_rst2", reset_indicator_out_n, 0);
		@(posedge core_clk) rst <= 0;
		bus(0, 8'h00, 0);
		chk("ctrl_rst2", rd, 0);
		// Mirrored size and status on the upper interrupt pins
		core_transfer_size <= 2'h2;
		core_processor_status <= 4'h9;
		int_lvl <= 8'hff;
		bus(1, 8'h00, 32'hc);
		#1 chk("int_o", int_pad.o[7:2], 6'h29);
		chk("int_oe", int_pad.oe[7:2], 6'h3f);
		chk("int_pu", int_pad.pu[7:2], 6'h00);
		@(posedge core_clk) emul_mode <= 1;
		repeat (3) @(posedge core_clk);
		#1 chk("eport_emul", eport_in, 8'h03);
		@(posedge core_clk) emul_mode <= 0;
		repeat (3) @(posedge core_clk);
		#1 chk("eport_norm", eport_in, 8'hff);
		// Pullups, open-drain and drive reduce; upper bits are dropped
		sci_oe <= 4'h5;
		spi_oe <= 4'h3;
		bus(1, 8'h00, 32'hfffff670);
		#1 chk("sci_pu", sci_pu, 4'ha);
		chk("spi_pu", spi_pu, 4'hc);
		chk("od", {spi_open_drain, sci_open_drain}, 2'h1);
		chk("drv", drive_reduce, 4'h9);
		// Status writes are dropped, so control keeps its value
		bus(1, 8'h04, 32'h1);
		bus(0, 8'h00, 0);
		chk("ctrl_rd", rd, 32'h1670);
		bus(0, 8'h08, 0);
		chk("unmapped", rd, 0);
		bus(0, 8'h04, 0);
		chk("stat", rd, 32'h00000ff5);
		// PLL test tristates the indicator two edges on
		@(posedge core_clk) want_pll_test <= 1;
		#1 chk("pll_e0", reset_indicator_oe, 1);
		repeat (2) @(posedge core_clk);
		#1 chk("pll_e2", reset_indicator_oe, 0);
		// Scan-only paths, test data out and debug pins
		@(posedge core_clk) bscan_en <= 1;
		scan_pin_i <= 3'h5;
		scan_reset_drive <= 1;
		{tdo_drive, tdo_data} <= 2'h3;
		{jtag_pin_i, debug_event_drive, debug_event_pin_i} <= 5'h1b;
		#1 chk("scan_cap", scan_capture, 3'h5);
		chk("scan_rst", {reset_pin_oe, reset_pin_o}, 2'h2);
		chk("tdo", {tdo_oe, tdo_o}, 2'h3);
		chk("jtag", {jtag_in, debug_pu}, 7'h6f);
		chk("de", {debug_event_pin_oe, debug_event_pin_o, debug_event_pin_pu}, 3'h4);
		chk("de_in", debug_event_in, 1);
		@(posedge core_clk) bscan_en <= 0;
		#1 chk("scan_off", {scan_capture, reset_pin_oe}, 4'h0);
		// Reset request: two flops normally, raw in stop mode
		@(posedge core_clk) want_reset <= 1;
		@(posedge core_clk);
		#1 chk("req_e1", reset_req_n, 1);
		@(posedge core_clk);
		#1 chk("req_e2", reset_req_n, 0);
		@(posedge core_clk) stop_mode <= 1;
		want_reset <= 0;
		#1 chk("req_stop", reset_req_n, 1);
		print_verdict();
	end
endmodule // testbench
